// *** sdram_command_power_fsm.sv ***
// command decode, bank tracking and power state machine of the memory device
// Operation
// [R1] commands decode from chip select, CA0..CA3 and clock gate at rising edge
// [R2] the three bank bits pick the single bank a command acts on
// [R3] read or write with auto precharge closes its bank after the burst
// [R4] CA bits sampled on both edges form two fields of one command
// [R5] chip select and clock gate sampled only on rising edges
// [R6] self refresh and deep sleep exits seen without a running clock
// [R7] per-bank refresh only on eight-bank parts; controller must not send otherwise
// [R8] column bit C0 is always taken as zero
// [R9] precharge with all-bank flag closes every bank, bank bits ignored
// [R10] clock gate low on consecutive edges keeps the low-power state
// [R11] clock gate rising with chip select high leaves active or idle power-down
// [R12] clock gate rising with chip select high in deep sleep gives power-on
// [R13] after self refresh exit controller sends only no-ops for the exit delay
// [R14] after power-down exit controller sends only no-ops for the exit delay
// [R15] clock gate falling with chip select high enters active or idle power-down
// [R16] resetting power-down exit goes idle only if init settle time expired
// [R17] controller never sends combinations outside the defined tables
// [R18] from idle activate opens a row; refresh starts per-bank or all-bank refresh
// [R19] mode register write loads a register; reset write starts auto initialisation
// [R20] precharge from idle or active closes rows and enters precharging
// [R21] active: read or write starts a burst; register read enters active reading
// [R22] reading: read restarts, write switches, burst stop returns to active
// [R23] writing: write restarts, read switches, burst stop returns to active
// [R24] power-on reset starts resetting; register read allowed while resetting
// [R25] controller sends no-op only when clock gate was level across two edges
// [R26] controller sends only no-ops in refresh and register access states
// [R27] a no-op continues the running operation and leaves banks unchanged
`timescale 1ns/1ps
`default_nettype none
module sdram_command_power_fsm #(
  parameter int num_banks = sdram_cmd_pkg::NUM_BANKS
) (
  input  wire logic                            sys_clk,
  input  wire logic                            rst,
  input  wire logic                            mem_clk,
  input  wire logic                            chip_select_low,
  input  wire logic                            clk_gate_input,
  input  wire logic [sdram_cmd_pkg::CA_W-1:0]  cmd_addr,
  output var  sdram_cmd_pkg::state_t           dev_state,
  output var  logic [7:0]                      bank_open,
  output var  sdram_cmd_pkg::cmd_t             last_cmd,
  output var  logic                            cmd_strobe,
  output var  logic                            init_done
);
  localparam int AP_WAIT_MAX = 16;

  // two-stage synchronisers; logic reads stage two, and for mem_clk also the delay flop mclk_d
  logic                           mclk_s1, mclk_s2, mclk_d;
  logic                           cs_s1, cs_s2, cke_s1, cke_s2;
  logic [sdram_cmd_pkg::CA_W-1:0] ca_s1, ca_s2;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {mclk_s1, mclk_s2, mclk_d} <= 3'h0;
      {cs_s1, cs_s2, cke_s1, cke_s2} <= 4'hF;
      ca_s1 <= '0;
      ca_s2 <= '0;
    end else begin
      mclk_s1 <= mem_clk;
      mclk_s2 <= mclk_s1;
      mclk_d  <= mclk_s2;
      cs_s1   <= chip_select_low;
      cs_s2   <= cs_s1;
      cke_s1  <= clk_gate_input;
      cke_s2  <= cke_s1;
      ca_s1   <= cmd_addr;
      ca_s2   <= ca_s1;
    end
  end

  logic mclk_rise, mclk_fall, exec;
  assign mclk_rise = mclk_s2 & ~mclk_d;
  assign mclk_fall = ~mclk_s2 & mclk_d;

  sdram_cmd_pkg::state_t          state_r, state_nxt;
  logic [7:0]                     bank_open_r, bank_open_nxt;
  logic [sdram_cmd_pkg::CA_W-1:0] ca_rise_r, ca_rise_nxt;
  logic                           pend_r, pend_nxt;
  logic                           cke_prev_r, cke_prev_nxt;
  logic                           cke_lvl_r, cke_lvl_nxt;
  logic [15:0]                    timer_r, timer_nxt;
  logic [15:0]                    init_tmr_r, init_tmr_nxt;
  logic                           init_done_r, init_done_nxt;
  logic                           ap_busy_r, ap_busy_nxt;
  logic [2:0]                     ap_bank_r, ap_bank_nxt;
  logic [15:0]                    ap_tmr_r, ap_tmr_nxt;
  sdram_cmd_pkg::cmd_t            cmd_r, cmd_nxt, dec;
  logic                           strobe_r, strobe_nxt;

  assign exec = mclk_fall & pend_r;

  always_comb begin
    state_nxt     = state_r;
    bank_open_nxt = bank_open_r;
    ca_rise_nxt   = ca_rise_r;
    pend_nxt      = pend_r;
    cke_prev_nxt  = cke_prev_r;
    cke_lvl_nxt   = cke_s2;
    timer_nxt     = (timer_r != 16'h0000) ? timer_r - 16'h0001 : timer_r;
    init_tmr_nxt  = init_tmr_r;
    init_done_nxt = init_done_r;
    ap_busy_nxt   = ap_busy_r;
    ap_bank_nxt   = ap_bank_r;
    ap_tmr_nxt    = (ap_tmr_r != 16'h0000) ? ap_tmr_r - 16'h0001 : ap_tmr_r;
    cmd_nxt       = cmd_r;
    strobe_nxt    = 1'b0;
    dec           = sdram_cmd_pkg::decode_cmd(ca_rise_r, ca_s2); // [R4]

    // init settle timer runs in resetting and its power-down
    if (state_r == sdram_cmd_pkg::ST_RESETTING || state_r == sdram_cmd_pkg::ST_RESET_PD) begin
      if (init_tmr_r != 16'h0000) begin
        init_tmr_nxt = init_tmr_r - 16'h0001;
      end else begin
        init_done_nxt = 1'b1;
      end
    end
    if (state_r == sdram_cmd_pkg::ST_RESETTING && init_done_r) begin
      state_nxt = sdram_cmd_pkg::ST_IDLE;
    end

    // end of timed states
    if (timer_r == 16'h0000) begin
      case (state_r)
        sdram_cmd_pkg::ST_PRECHARGE: begin
          state_nxt = (bank_open_r != 8'h00) ? sdram_cmd_pkg::ST_ACTIVE : sdram_cmd_pkg::ST_IDLE;
        end
        sdram_cmd_pkg::ST_REF_PB, sdram_cmd_pkg::ST_REF_AB,
        sdram_cmd_pkg::ST_MR_WRITE, sdram_cmd_pkg::ST_MRR_IDLE: begin
          state_nxt = sdram_cmd_pkg::ST_IDLE;
        end
        sdram_cmd_pkg::ST_MRR_ACTIVE: state_nxt = sdram_cmd_pkg::ST_ACTIVE;
        sdram_cmd_pkg::ST_MRR_RESET:  state_nxt = sdram_cmd_pkg::ST_RESETTING;
        default: ;
      endcase
    end

    // auto precharge fires once the burst time has run out
    if (ap_busy_r && ap_tmr_r == 16'h0000) begin
      ap_busy_nxt = 1'b0;
      bank_open_nxt[ap_bank_r] = 1'b0; // [R3]
      if (state_r == sdram_cmd_pkg::ST_READING || state_r == sdram_cmd_pkg::ST_WRITING) begin
        state_nxt = ((bank_open_r & ~(8'h01 << ap_bank_r)) != 8'h00) ?
                    sdram_cmd_pkg::ST_ACTIVE : sdram_cmd_pkg::ST_IDLE;
      end
    end

    // rising edge: gate and select are single rate
    if (mclk_rise) begin
      cke_prev_nxt = cke_s2; // [R5]
      pend_nxt     = 1'b0;
      case ({cke_prev_r, cke_s2})
        2'h3: begin
          // chip select high is a no-op and leaves all state alone
          if (!cs_s2) begin
            ca_rise_nxt = ca_s2; // [R1]
            pend_nxt    = 1'b1;
          end
        end
        2'h2: begin
          if (cs_s2) begin
            case (state_r) // [R15]
              sdram_cmd_pkg::ST_RESETTING: state_nxt = sdram_cmd_pkg::ST_RESET_PD;
              sdram_cmd_pkg::ST_IDLE, sdram_cmd_pkg::ST_ACTIVE: begin
                state_nxt = (bank_open_r != 8'h00) ? sdram_cmd_pkg::ST_ACTIVE_PD
                                                   : sdram_cmd_pkg::ST_IDLE_PD;
              end
              default: ;
            endcase
          end else if (state_r == sdram_cmd_pkg::ST_IDLE) begin
            if (ca_s2[2:0] == sdram_cmd_pkg::OPC_SRE) begin
              state_nxt = sdram_cmd_pkg::ST_SELF_REF;
            end else if (ca_s2[2:0] == sdram_cmd_pkg::OPC_DPD) begin
              state_nxt = sdram_cmd_pkg::ST_DEEP_SLEEP;
            end
          end
        end
        2'h1: begin
          if (cs_s2) begin
            case (state_r) // [R11]
              sdram_cmd_pkg::ST_ACTIVE_PD: state_nxt = sdram_cmd_pkg::ST_ACTIVE;
              sdram_cmd_pkg::ST_IDLE_PD:   state_nxt = sdram_cmd_pkg::ST_IDLE;
              sdram_cmd_pkg::ST_RESET_PD: begin
                state_nxt = sdram_cmd_pkg::ST_RESETTING;
                if (init_done_r) state_nxt = sdram_cmd_pkg::ST_IDLE; // [R16]
              end
              default: ;
            endcase
          end
        end
        default: ; // gate held low: stay in the low-power state [R10]
      endcase
    end

    // falling edge completes a two-half command
    if (exec) begin
      pend_nxt   = 1'b0;
      cmd_nxt    = dec; // [R8]
      strobe_nxt = 1'b1;
      case (state_r)
        sdram_cmd_pkg::ST_IDLE, sdram_cmd_pkg::ST_ACTIVE: begin
          case (dec.kind)
            sdram_cmd_pkg::CMD_ACT: begin
              bank_open_nxt[dec.bank] = 1'b1; // [R2] [R18]
              state_nxt = sdram_cmd_pkg::ST_ACTIVE;
            end
            sdram_cmd_pkg::CMD_PRE: begin
              if (dec.ab) bank_open_nxt = 8'h00; // [R9]
              else        bank_open_nxt[dec.bank] = 1'b0; // [R20]
              state_nxt = sdram_cmd_pkg::ST_PRECHARGE;
              timer_nxt = 16'(sdram_cmd_pkg::T_RP_CYC - 1);
            end
            sdram_cmd_pkg::CMD_MRR: begin
              state_nxt = (state_r == sdram_cmd_pkg::ST_IDLE) ? sdram_cmd_pkg::ST_MRR_IDLE
                                                             : sdram_cmd_pkg::ST_MRR_ACTIVE;
              timer_nxt = 16'(sdram_cmd_pkg::T_MRR_CYC - 1); // [R21]
            end
            sdram_cmd_pkg::CMD_RD, sdram_cmd_pkg::CMD_WR: begin
              if (state_r == sdram_cmd_pkg::ST_ACTIVE) begin
                state_nxt = sdram_cmd_pkg::ST_WRITING; // [R21]
                if (dec.kind == sdram_cmd_pkg::CMD_RD) state_nxt = sdram_cmd_pkg::ST_READING;
                ap_busy_nxt = dec.ap; // [R3]
                ap_bank_nxt = dec.bank;
                ap_tmr_nxt  = 16'(sdram_cmd_pkg::T_BURST_CYC - 1);
              end
            end
            sdram_cmd_pkg::CMD_REFPB: begin
              // single-bank refresh exists only on eight-bank parts
              if (state_r == sdram_cmd_pkg::ST_IDLE && num_banks == 8) begin // [R7]
                state_nxt = sdram_cmd_pkg::ST_REF_PB; // [R18]
                timer_nxt = 16'(sdram_cmd_pkg::T_RFCPB_CYC - 1);
              end
            end
            sdram_cmd_pkg::CMD_REFAB: begin
              if (state_r == sdram_cmd_pkg::ST_IDLE) begin
                state_nxt = sdram_cmd_pkg::ST_REF_AB; // [R18]
                timer_nxt = 16'(sdram_cmd_pkg::T_RFCAB_CYC - 1);
              end
            end
            sdram_cmd_pkg::CMD_MRW: begin
              if (state_r == sdram_cmd_pkg::ST_IDLE) begin
                if (dec.ma == sdram_cmd_pkg::RESET_MR_ADDR) begin
                  state_nxt     = sdram_cmd_pkg::ST_RESETTING; // [R19]
                  bank_open_nxt = 8'h00;
                  init_tmr_nxt  = 16'(sdram_cmd_pkg::T_INIT5_CYC - 1);
                  init_done_nxt = 1'b0;
                end else begin
                  state_nxt = sdram_cmd_pkg::ST_MR_WRITE; // [R19]
                  timer_nxt = 16'(sdram_cmd_pkg::T_MRW_CYC - 1);
                end
              end
            end
            default: ; // no-op keeps everything running [R27]
          endcase
        end
        sdram_cmd_pkg::ST_READING, sdram_cmd_pkg::ST_WRITING: begin
          case (dec.kind) // [R22] [R23]
            sdram_cmd_pkg::CMD_RD, sdram_cmd_pkg::CMD_WR: begin
              state_nxt = (dec.kind == sdram_cmd_pkg::CMD_RD) ? sdram_cmd_pkg::ST_READING
                                                             : sdram_cmd_pkg::ST_WRITING;
              ap_busy_nxt = dec.ap;
              ap_bank_nxt = dec.bank;
              ap_tmr_nxt  = 16'(sdram_cmd_pkg::T_BURST_CYC - 1);
            end
            sdram_cmd_pkg::CMD_BST: begin
              state_nxt   = sdram_cmd_pkg::ST_ACTIVE;
              ap_busy_nxt = 1'b0;
            end
            default: ;
          endcase
        end
        sdram_cmd_pkg::ST_POWER_ON: begin
          if (dec.kind == sdram_cmd_pkg::CMD_MRW && dec.ma == sdram_cmd_pkg::RESET_MR_ADDR) begin
            state_nxt     = sdram_cmd_pkg::ST_RESETTING; // [R24]
            init_tmr_nxt  = 16'(sdram_cmd_pkg::T_INIT5_CYC - 1);
            init_done_nxt = 1'b0;
          end
        end
        sdram_cmd_pkg::ST_RESETTING: begin
          if (dec.kind == sdram_cmd_pkg::CMD_MRR) begin
            state_nxt = sdram_cmd_pkg::ST_MRR_RESET; // [R24]
            timer_nxt = 16'(sdram_cmd_pkg::T_MRR_CYC - 1);
          end
        end
        default: ;
      endcase
    end

    // exits from self refresh and deep sleep need no clock edge at all
    if (cke_s2 && !cke_lvl_r && cs_s2) begin
      if (state_r == sdram_cmd_pkg::ST_SELF_REF) begin
        state_nxt    = sdram_cmd_pkg::ST_IDLE; // [R6]
        cke_prev_nxt = 1'b1;
      end else if (state_r == sdram_cmd_pkg::ST_DEEP_SLEEP) begin
        state_nxt     = sdram_cmd_pkg::ST_POWER_ON; // [R6] [R12]
        bank_open_nxt = 8'h00;
        init_done_nxt = 1'b0;
        cke_prev_nxt  = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r     <= sdram_cmd_pkg::ST_POWER_ON;
      bank_open_r <= 8'h00;
      ca_rise_r   <= '0;
      pend_r      <= 1'b0;
      cke_prev_r  <= 1'b1;
      cke_lvl_r   <= 1'b1;
      timer_r     <= 16'h0000;
      init_tmr_r  <= 16'h0000;
      init_done_r <= 1'b0;
      ap_busy_r   <= 1'b0;
      ap_bank_r   <= 3'h0;
      ap_tmr_r    <= 16'h0000;
      cmd_r       <= '0;
      strobe_r    <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      bank_open_r <= bank_open_nxt;
      ca_rise_r   <= ca_rise_nxt;
      pend_r      <= pend_nxt;
      cke_prev_r  <= cke_prev_nxt;
      cke_lvl_r   <= cke_lvl_nxt;
      timer_r     <= timer_nxt;
      init_tmr_r  <= init_tmr_nxt;
      init_done_r <= init_done_nxt;
      ap_busy_r   <= ap_busy_nxt;
      ap_bank_r   <= ap_bank_nxt;
      ap_tmr_r    <= ap_tmr_nxt;
      cmd_r       <= cmd_nxt;
      strobe_r    <= strobe_nxt;
    end
  end

  assign dev_state  = state_r;
  assign bank_open  = bank_open_r;
  assign last_cmd   = cmd_r;
  assign cmd_strobe = strobe_r;
  assign init_done  = init_done_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_rise_sample: assert property (mclk_rise && cke_prev_r && cke_s2 && !cs_s2 |=> // [R1] [R5]
    pend_r && ca_rise_r == $past(ca_s2)) else $error("rising command half not captured");
  a_fall_field: assert property (exec |=> cmd_strobe && last_cmd.ap == $past(ca_s2[0])) // [R4]
    else $error("falling half not used as command field");
  a_col_lsb_zero: assert property (cmd_strobe |-> last_cmd.col[0] == 1'b0) // [R8]
    else $error("column bit zero not forced low");
  a_ap_close: assert property (exec && state_r == sdram_cmd_pkg::ST_ACTIVE && dec.ap && // [R3]
    dec.kind == sdram_cmd_pkg::CMD_RD |-> ##[1:AP_WAIT_MAX] !ap_busy_r)
    else $error("auto precharge never completed");
  a_pre_all: assert property (exec && dec.kind == sdram_cmd_pkg::CMD_PRE && dec.ab && // [R9]
    (state_r == sdram_cmd_pkg::ST_IDLE || state_r == sdram_cmd_pkg::ST_ACTIVE) |=>
    bank_open == 8'h00) else $error("all-bank precharge left a bank open");
  a_act_open: assert property (exec && dec.kind == sdram_cmd_pkg::CMD_ACT && // [R2] [R18]
    state_r == sdram_cmd_pkg::ST_IDLE |=> bank_open[$past(dec.bank)] &&
    dev_state == sdram_cmd_pkg::ST_ACTIVE) else $error("activate did not open bank");
  a_pd_entry: assert property (mclk_rise && cke_prev_r && !cke_s2 && cs_s2 && // [R15]
    state_r == sdram_cmd_pkg::ST_ACTIVE |=> dev_state == sdram_cmd_pkg::ST_ACTIVE_PD)
    else $error("active power-down not entered");
  a_pd_exit: assert property (mclk_rise && !cke_prev_r && cke_s2 && cs_s2 && // [R11]
    state_r == sdram_cmd_pkg::ST_IDLE_PD |=> dev_state == sdram_cmd_pkg::ST_IDLE)
    else $error("idle power-down exit failed");
  a_pd_hold: assert property (mclk_rise && !cke_prev_r && !cke_s2 && // [R10]
    state_r == sdram_cmd_pkg::ST_IDLE_PD |=> $stable(dev_state))
    else $error("power-down left early");
  a_reset_pd_exit: assert property (mclk_rise && !cke_prev_r && cke_s2 && cs_s2 && // [R16]
    !init_done_r && state_r == sdram_cmd_pkg::ST_RESET_PD |=>
    dev_state == sdram_cmd_pkg::ST_RESETTING)
    else $error("resetting power-down exit skipped settle time");
  a_async_exit: assert property (cke_s2 && !cke_lvl_r && cs_s2 && // [R6] [R12]
    state_r == sdram_cmd_pkg::ST_DEEP_SLEEP |=> dev_state == sdram_cmd_pkg::ST_POWER_ON)
    else $error("deep sleep exit missed");
  a_bst_end: assert property (exec && dec.kind == sdram_cmd_pkg::CMD_BST && // [R22] [R23]
    state_r == sdram_cmd_pkg::ST_READING |=> dev_state == sdram_cmd_pkg::ST_ACTIVE)
    else $error("burst stop did not end the read");

  c_self_ref: cover property (dev_state == sdram_cmd_pkg::ST_SELF_REF ##[1:200]
    dev_state == sdram_cmd_pkg::ST_IDLE);
  c_read_ap: cover property (dev_state == sdram_cmd_pkg::ST_READING && ap_busy_r);
  c_reset_init: cover property (dev_state == sdram_cmd_pkg::ST_RESETTING ##1 init_done);
  c_power_down: cover property (dev_state == sdram_cmd_pkg::ST_ACTIVE_PD);
endmodule : sdram_command_power_fsm
`default_nettype wire

// *** sdram_cmd_pkg.sv ***
// constants, types and the command decoder for the command and power state machine
package sdram_cmd_pkg;
  localparam int          CLK_MHZ       = 125;
  localparam int          NUM_BANKS     = 8;
  localparam int          CA_W          = 10;
  // timing figures in ns
  localparam int          T_RP_NS       = 18;
  localparam int          T_RFCPB_NS    = 60;
  localparam int          T_RFCAB_NS    = 130;
  localparam int          T_MRR_NS      = 16;
  localparam int          T_MRW_NS      = 40;
  localparam int          T_INIT5_NS    = 10000;
  localparam int          T_BURST_NS    = 32;
  // least times, rounded up to whole sys_clk cycles
  localparam int          T_RP_CYC      = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int          T_RFCPB_CYC   = (T_RFCPB_NS * CLK_MHZ + 999) / 1000;
  localparam int          T_RFCAB_CYC   = (T_RFCAB_NS * CLK_MHZ + 999) / 1000;
  localparam int          T_MRR_CYC     = (T_MRR_NS * CLK_MHZ + 999) / 1000;
  localparam int          T_MRW_CYC     = (T_MRW_NS * CLK_MHZ + 999) / 1000;
  localparam int          T_INIT5_CYC   = (T_INIT5_NS * CLK_MHZ + 999) / 1000;
  localparam int          T_BURST_CYC   = (T_BURST_NS * CLK_MHZ + 999) / 1000;
  // opcode patterns, bit i is the rising sample of command/address bit i
  localparam logic [3:0]  OPC_MRW       = 4'h0;
  localparam logic [3:0]  OPC_MRR       = 4'h8;
  localparam logic [3:0]  OPC_REFPB     = 4'h4;
  localparam logic [3:0]  OPC_REFAB     = 4'hC;
  localparam logic [3:0]  OPC_PRE       = 4'hB;
  localparam logic [3:0]  OPC_BST       = 4'h3;
  localparam logic [1:0]  OPC_ACT       = 2'h2;
  localparam logic [2:0]  OPC_WR        = 3'h1;
  localparam logic [2:0]  OPC_RD        = 3'h5;
  localparam logic [2:0]  OPC_NOP       = 3'h7;
  localparam logic [2:0]  OPC_SRE       = 3'h4;
  localparam logic [2:0]  OPC_DPD       = 3'h3;
  localparam logic [7:0]  RESET_MR_ADDR = 8'h3F;
  localparam int          BANK_LSB      = 7;
  localparam int          AB_BIT        = 4;
  localparam int          AP_BIT        = 0;

  typedef enum logic [3:0] {
    CMD_NOP, CMD_MRW, CMD_MRR, CMD_REFPB, CMD_REFAB, CMD_ACT,
    CMD_WR, CMD_RD, CMD_PRE, CMD_BST, CMD_BAD
  } cmd_kind_t;

  typedef struct packed {
    cmd_kind_t   kind;
    logic [2:0]  bank;
    logic        ap;
    logic        ab;
    logic [7:0]  ma;
    logic [7:0]  op;
    logic [11:0] col;
  } cmd_t;

  typedef enum logic [17:0] {
    ST_POWER_ON   = 18'h0_0001, ST_RESETTING  = 18'h0_0002,
    ST_IDLE       = 18'h0_0004, ST_ACTIVE     = 18'h0_0008,
    ST_READING    = 18'h0_0010, ST_WRITING    = 18'h0_0020,
    ST_PRECHARGE  = 18'h0_0040, ST_REF_PB     = 18'h0_0080,
    ST_REF_AB     = 18'h0_0100, ST_MR_WRITE   = 18'h0_0200,
    ST_MRR_IDLE   = 18'h0_0400, ST_MRR_ACTIVE = 18'h0_0800,
    ST_MRR_RESET  = 18'h0_1000, ST_ACTIVE_PD  = 18'h0_2000,
    ST_IDLE_PD    = 18'h0_4000, ST_RESET_PD   = 18'h0_8000,
    ST_SELF_REF   = 18'h1_0000, ST_DEEP_SLEEP = 18'h2_0000
  } state_t;

  function automatic cmd_t decode_cmd(input logic [CA_W-1:0] r, input logic [CA_W-1:0] f);
    cmd_t c;
    c.bank = r[BANK_LSB +: 3];
    c.ap   = f[AP_BIT];
    c.ab   = r[AB_BIT];
    c.ma   = {f[1:0], r[9:4]};
    c.op   = f[9:2];
    c.col  = {f[9:1], r[6:5], 1'b0};
    if (r[2:0] == OPC_NOP)        c.kind = CMD_NOP;
    else if (r[1:0] == OPC_ACT)   c.kind = CMD_ACT;
    else if (r[2:0] == OPC_WR)    c.kind = CMD_WR;
    else if (r[2:0] == OPC_RD)    c.kind = CMD_RD;
    else if (r[3:0] == OPC_MRW)   c.kind = CMD_MRW;
    else if (r[3:0] == OPC_MRR)   c.kind = CMD_MRR;
    else if (r[3:0] == OPC_REFPB) c.kind = CMD_REFPB;
    else if (r[3:0] == OPC_REFAB) c.kind = CMD_REFAB;
    else if (r[3:0] == OPC_PRE)   c.kind = CMD_PRE;
    else if (r[3:0] == OPC_BST)   c.kind = CMD_BST;
    else                          c.kind = CMD_BAD;
    return c;
  endfunction : decode_cmd
endpackage : sdram_cmd_pkg

// *** sdram_ctl_model.sv ***
// controller model for the command bus, clock gate and select
`timescale 1ns/1ps
`default_nettype none
module sdram_ctl_model (
  output var logic                           mem_clk,
  output var logic                           chip_select_low,
  output var logic                           clk_gate_input,
  output var logic [sdram_cmd_pkg::CA_W-1:0] cmd_addr
);
  initial {mem_clk, chip_select_low, clk_gate_input, cmd_addr} = {3'b011, 10'h3FF};
  // one clock period per command; the clock stands low between commands
  task automatic send(input logic [9:0] r, input logic [9:0] f, input logic [1:0] p);
    {chip_select_low, clk_gate_input} = p;
    cmd_addr = r;
    #16 mem_clk = 1'b1;
    #16 cmd_addr = f;
    #16 mem_clk = 1'b0;
    #16 cmd_addr = ~f; // released bus must not keep the last value
    #8; // gap so back-to-back frames never drive a pin twice in one step
  endtask : send
  task automatic no_op_cmd();
    send(10'h3FF, 10'h3FF, 2'b11);
  endtask : no_op_cmd
  task automatic pins(input logic [1:0] p);
    {chip_select_low, clk_gate_input} = p;
  endtask : pins
endmodule : sdram_ctl_model
`default_nettype wire

// *** sdram_command_power_fsm_tb.sv ***
// self-checking bench for the command and power state machine
`timescale 1ns/1ps
`default_nettype none
module sdram_command_power_fsm_tb;
  logic                  sys_clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  mem_clk, chip_select_low, clk_gate_input, cmd_strobe, init_done;
  logic [9:0]            cmd_addr;
  logic [7:0]            bank_open;
  sdram_cmd_pkg::state_t dev_state;
  sdram_cmd_pkg::cmd_t   last_cmd;
  int                    bad_count = 0, total_checks = 0;
  always #4 sys_clk = ~sys_clk;
  sdram_ctl_model ctl (.mem_clk(mem_clk), .chip_select_low(chip_select_low),
    .clk_gate_input(clk_gate_input), .cmd_addr(cmd_addr));
  sdram_command_power_fsm #(.num_banks(8)) dut (.sys_clk(sys_clk), .rst(rst), .mem_clk(mem_clk),
    .chip_select_low(chip_select_low), .clk_gate_input(clk_gate_input), .cmd_addr(cmd_addr),
    .dev_state(dev_state), .bank_open(bank_open), .last_cmd(last_cmd),
    .cmd_strobe(cmd_strobe), .init_done(init_done));
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) $display("[FAIL] t=%0t seen %0h expected %0h", $time, seen, exp);
    if (seen !== exp) bad_count++;
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk) #1;
  endtask : tick
  task automatic await(input int lim, ref logic sig);
    int n;
    for (n = 0; sig !== 1'b1 && n < lim; n++) tick(1);
    if (sig !== 1'b1) begin
      bad_count++;
      summarize();
    end
  endtask : await
  // p is {select, gate}; only a selected command with the gate high is strobed
  task automatic step(input logic [9:0] r, input logic [1:0] p, input sdram_cmd_pkg::state_t exp,
                      input logic [9:0] f = 10'h000, input int bo = -1);
    ctl.send(r, f, p);
    if (p == 2'b01) await(12, cmd_strobe);
    else tick(6);
    chk(dev_state, exp);
    if (bo >= 0) chk(bank_open, bo[7:0]);
  endtask : step
  task automatic t_reset();
    chk(dev_state, sdram_cmd_pkg::ST_POWER_ON);
    step(10'h3F0, 2'b01, sdram_cmd_pkg::ST_RESETTING);
    step(10'h3FF, 2'b10, sdram_cmd_pkg::ST_RESET_PD);
    step(10'h3FF, 2'b11, sdram_cmd_pkg::ST_RESETTING);
    await(2000, init_done);
    tick(2);
    chk(dev_state, sdram_cmd_pkg::ST_IDLE);
    $display("reset test done");
  endtask : t_reset
  task automatic t_power();
    step(10'h004, 2'b01, sdram_cmd_pkg::ST_REF_PB);
    ctl.no_op_cmd();
    step(10'h000, 2'b01, sdram_cmd_pkg::ST_MR_WRITE);
    ctl.no_op_cmd();
    step(10'h282, 2'b01, sdram_cmd_pkg::ST_ACTIVE, 10'h000, 8'h20);
    step(10'h008, 2'b01, sdram_cmd_pkg::ST_MRR_ACTIVE);
    ctl.no_op_cmd();
    step(10'h3FF, 2'b10, sdram_cmd_pkg::ST_ACTIVE_PD);
    step(10'h3FF, 2'b11, sdram_cmd_pkg::ST_ACTIVE);
    ctl.no_op_cmd();
    step(10'h2E5, 2'b01, sdram_cmd_pkg::ST_READING, 10'h001);
    chk(last_cmd.ap, 1'b1);
    tick(6);
    chk(dev_state, sdram_cmd_pkg::ST_IDLE);
    chk(bank_open, 8'h00);
    step(10'h3FC, 2'b00, sdram_cmd_pkg::ST_SELF_REF);
    ctl.pins(2'b11);
    tick(6);
    chk(dev_state, sdram_cmd_pkg::ST_IDLE);
    ctl.no_op_cmd();
    $display("mode, refresh and low-power test done");
  endtask : t_power
  task automatic t_ops();
    step(10'h282, 2'b01, sdram_cmd_pkg::ST_ACTIVE, 10'h000, 8'h20);
    step(10'h2E1, 2'b01, sdram_cmd_pkg::ST_WRITING, 10'h3FE);
    chk(last_cmd.col, 12'hFFE);
    step(10'h2E5, 2'b01, sdram_cmd_pkg::ST_READING);
    step(10'h003, 2'b01, sdram_cmd_pkg::ST_ACTIVE);
    chk(last_cmd.kind, sdram_cmd_pkg::CMD_BST);
    step(10'h3FF, 2'b11, sdram_cmd_pkg::ST_ACTIVE, 10'h000, 8'h20);
    step(10'h01B, 2'b01, sdram_cmd_pkg::ST_PRECHARGE, 10'h000, 8'h00);
    ctl.no_op_cmd();
    step(10'h3FF, 2'b10, sdram_cmd_pkg::ST_IDLE_PD);
    step(10'h3FF, 2'b10, sdram_cmd_pkg::ST_IDLE_PD);
    step(10'h3FF, 2'b11, sdram_cmd_pkg::ST_IDLE);
    ctl.no_op_cmd();
    step(10'h003, 2'b00, sdram_cmd_pkg::ST_DEEP_SLEEP);
    ctl.pins(2'b11);
    tick(6);
    chk(dev_state, sdram_cmd_pkg::ST_POWER_ON);
    $display("command and power test done");
  endtask : t_ops
  initial begin
    repeat (5) @(posedge sys_clk);
    #1 rst = 1'b0;
    tick(3);
    t_reset();
    t_power();
    t_ops();
    summarize();
  end
endmodule : sdram_command_power_fsm_tb
`default_nettype wire
